/* inc/ccdet_map.vh */
// register offsets, field positions, reset values and timing counts of the exposure block
`ifndef CCDET_MAP_VH
`define CCDET_MAP_VH

// ==========================================================
// register offsets (byte addresses, host register port)
`define CCDET_WR_COMMAND      6'h00
`define CCDET_WR_TIMER_LOW    6'h04
`define CCDET_WR_VBIN         6'h08
`define CCDET_RD_COMMAND      6'h20
`define CCDET_RD_TIMER_LOW    6'h24
`define CCDET_RD_VBIN         6'h28

// ==========================================================
// command register bit positions
`define CCDET_CMD_DRIFT_SCAN   0
`define CCDET_CMD_START_EXPO   1
`define CCDET_CMD_SHUT_FORCE   2
`define CCDET_CMD_CTRL_RESET   3
`define CCDET_CMD_LINE_CACHE   4
`define CCDET_CMD_TRIG_ENABLE  5
`define CCDET_CMD_STOP_FLUSH   6
`define CCDET_CMD_SHUT_ENABLE  7
`define CCDET_CMD_COOL_RAMP    8
`define CCDET_CMD_DONE_READ    9
`define CCDET_CMD_TIMER_LOAD   10
`define CCDET_CMD_NEXT_LINE    11
`define CCDET_CMD_START_FLUSH  12
`define CCDET_CMD_FOCUS        13
`define CCDET_CMD_LONG_CABLE   14
`define CCDET_CMD_COOL_ENABLE  15

// ==========================================================
// vertical binning register fields
`define CCDET_VBIN_TMR_HI_MSB  3
`define CCDET_VBIN_TMR_HI_LSB  0
`define CCDET_VBIN_COUNT_MSB   13
`define CCDET_VBIN_COUNT_LSB   8

// ==========================================================
// reset values
`define CCDET_COMMAND_RESET    16'h0000
`define CCDET_TIMER_RESET      20'h00000
`define CCDET_VBIN_RESET       6'h00

// ==========================================================
// timing: timer step and clock period, in nanoseconds
`define CCDET_TICK_NS          10000000
`define CCDET_CLK_PERIOD_NS    5
`define CCDET_TICK_CYCLES      (`CCDET_TICK_NS / `CCDET_CLK_PERIOD_NS)

`endif

/* testbench/ccdet_readout_model.sv */
// readout engine stand-in that answers skip and line requests after a delay
`timescale 1ns/1ps
`default_nettype none

module ccdet_readout_model (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // handshake with the block
   input  wire logic row_skip_req_in,
   input  wire logic line_req_in,
   input  wire logic slow_in,
   output var  logic row_skip_done_out,
   output var  logic line_done_out
);
   logic [3:0] cnt_q;
   logic       kind_q;

   // ==========================================================
   // one-cycle answers, quick or slow
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= 4'h0;
         kind_q <= 1'b0;
         row_skip_done_out <= 1'b0;
         line_done_out <= 1'b0;
      end else begin
         row_skip_done_out <= 1'b0;
         line_done_out <= 1'b0;
         if (row_skip_req_in || line_req_in) begin
            cnt_q <= slow_in ? 4'h9 : 4'h2;
            kind_q <= line_req_in;
         end else if (cnt_q == 4'h1) begin
            cnt_q <= 4'h0;
            row_skip_done_out <= !kind_q;
            line_done_out <= kind_q;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/ccdet_top_chk.sv */
// assertion checker for the exposure command block, bound to its top
`timescale 1ns/1ps
`default_nettype none

module ccdet_top_chk (
   // clock and reset
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   // register port
   input wire logic [5:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        reg_rvalid_out,
   // sequencer and levels
   input wire logic        row_skip_req_out,
   input wire logic        line_ready_out,
   input wire logic        line_ack_out,
   input wire logic        flush_active_out,
   input wire logic        exposing_out,
   input wire logic        ctrl_reset_out,
   input wire logic        shutter_open_out,
   input wire logic        drift_scan_out,
   input wire logic        line_cache_out,
   input wire logic        cooler_ramp_out,
   input wire logic        cooler_regulate_out,
   input wire logic        focus_mode_out,
   input wire logic        long_cable_out,
   input wire logic [5:0]  vbin_count_out,
   input wire logic [19:0] timer_value_out
);
   // ==========================================================
   // shadow of the command register, kept from the write strobes
   logic [15:0] cmd_q;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in)
         cmd_q <= 16'h0000;
      else if (reg_wr_in && reg_addr_in == 6'h00)
         cmd_q <= reg_wdata_in;
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   // ==========================================================
   // properties
   a_shutter_level: assert property (
      shutter_open_out == (cmd_q[2] | (exposing_out & cmd_q[7])))
      else $error("shutter level wrong");
   a_level_bits: assert property (
      {drift_scan_out, line_cache_out, cooler_ramp_out, focus_mode_out, long_cable_out,
       cooler_regulate_out} == {cmd_q[0], cmd_q[4], cmd_q[8], cmd_q[13], cmd_q[14], cmd_q[15]})
      else $error("level outputs differ from command");
   a_read_timing: assert property (reg_rvalid_out == $past(reg_rd_in))
      else $error("read valid not one cycle after strobe");
   a_timer_read: assert property (
      reg_rd_in && reg_addr_in == 6'h24 |=> reg_rdata_out == $past(timer_value_out[15:0]))
      else $error("timer read not running value");
   a_vbin_write: assert property (
      reg_wr_in && reg_addr_in == 6'h08 |=> vbin_count_out == $past(reg_wdata_in[13:8]))
      else $error("binning count not stored");
   a_timer_loads: assert property (
      reg_wr_in && reg_addr_in == 6'h04 && cmd_q[10]
      |=> timer_value_out[15:0] == $past(reg_wdata_in))
      else $error("timer low not loaded");
   a_timer_frozen: assert property (
      !exposing_out && !(reg_wr_in && cmd_q[10]) |=> $stable(timer_value_out))
      else $error("timer moved outside exposure");
   a_timer_step: assert property (
      exposing_out |=> timer_value_out == $past(timer_value_out)
                    || timer_value_out == $past(timer_value_out) - 20'h1)
      else $error("timer step not one");
   a_skip_at_zero: assert property (row_skip_req_out |-> timer_value_out == 20'h0)
      else $error("row skip before timer ran out");
   a_ack_from_ready: assert property (line_ack_out |-> $past(line_ready_out))
      else $error("line ack without waiting line");
   a_ctrl_idle: assert property (
      ctrl_reset_out |=> !ctrl_reset_out && !exposing_out && !line_ready_out && !flush_active_out)
      else $error("control reset left sequencer busy");
endmodule

bind ccdet_top ccdet_top_chk ccdet_top_chk_inst (.clock_in, .rst_b_in, .reg_addr_in, .reg_wr_in,
   .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .row_skip_req_out, .line_ready_out,
   .line_ack_out, .flush_active_out, .exposing_out, .ctrl_reset_out, .shutter_open_out,
   .drift_scan_out, .line_cache_out, .cooler_ramp_out, .cooler_regulate_out, .focus_mode_out,
   .long_cable_out, .vbin_count_out, .timer_value_out);
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the exposure command block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int TK = 4;
   logic        clock_in, rst_b_in, reg_wr_in, reg_rd_in, ext_trigger_in, slow;
   logic [5:0]  reg_addr_in, vbin_count_out;
   logic [15:0] reg_wdata_in, reg_rdata_out;
   logic        reg_rvalid_out, row_skip_req_out, row_skip_done_in, line_req_out, line_done_in;
   logic        line_ready_out, line_ack_out, flush_active_out, exposing_out, ctrl_reset_out;
   logic        shutter_open_out, drift_scan_out, line_cache_out, cooler_ramp_out;
   logic        cooler_regulate_out, focus_mode_out, long_cable_out;
   logic [19:0] timer_value_out;
   logic [6:0]  ev, lv;
   int          failures, checks_done;

   assign ev = {line_req_out, ctrl_reset_out, flush_active_out, line_ack_out, line_ready_out,
                row_skip_req_out, exposing_out};
   assign lv = {drift_scan_out, shutter_open_out, line_cache_out, cooler_ramp_out,
                focus_mode_out, long_cable_out, cooler_regulate_out};

   ccdet_top #(.TICK_CYCLES(TK)) ccdet_top_inst (.clock_in, .rst_b_in, .reg_addr_in, .reg_wr_in,
      .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .ext_trigger_in,
      .row_skip_req_out, .row_skip_done_in, .line_req_out, .line_done_in, .line_ready_out,
      .line_ack_out, .flush_active_out, .exposing_out, .ctrl_reset_out, .shutter_open_out,
      .drift_scan_out, .line_cache_out, .cooler_ramp_out, .cooler_regulate_out,
      .focus_mode_out, .long_cable_out, .vbin_count_out, .timer_value_out);

   ccdet_readout_model ccdet_readout_model_inst (.clock_in, .rst_b_in,
      .row_skip_req_in(row_skip_req_out), .line_req_in(line_req_out), .slow_in(slow),
      .row_skip_done_out(row_skip_done_in), .line_done_out(line_done_in));

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   // ==========================================================
   // shared tasks
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clock_in);
      reg_wr_in = 1'b0;
   endtask

   task automatic cmd(input logic [15:0] d);
      wr(6'h00, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clock_in);
      reg_rd_in = 1'b0;
      chk({19'h0, reg_rvalid_out}, 20'h1);
      chk({4'h0, reg_rdata_out}, {4'h0, e});
   endtask

   // a wait that runs out counts as a failure and closes the run
   task automatic wait_on(input int sel, input int lim, output int n);
      n = 0;
      while (ev[sel] !== 1'b1) begin
         @(negedge clock_in);
         n++;
         if (n > lim) begin
            chk(20'h0, 20'h1);
            print_verdict();
         end
      end
   endtask

   task automatic rst_ctl(input logic [15:0] base);
      int n;
      cmd(base | 16'h0008);
      cmd(base);
      wait_on(5, 6, n);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset_regs;
      rd(6'h20, 16'h0000);
      rd(6'h24, 16'h0000);
      rd(6'h28, 16'h0000);
      rd(6'h2c, 16'h0000);
      chk({13'h0, lv}, 20'h0);
   endtask

   task automatic t_levels;
      int b[7] = '{0, 2, 4, 8, 13, 14, 15};
      for (int i = 0; i < 7; i++) begin
         cmd(16'h0001 << b[i]);
         chk({13'h0, lv}, 20'h40 >> i);
         rd(6'h20, 16'h0001 << b[i]);
      end
      cmd(16'h0000);
      chk({13'h0, lv}, 20'h0);
   endtask

   task automatic t_timer;
      rst_ctl(16'h0000);
      wr(6'h04, 16'h0003);
      rd(6'h24, 16'h0000);
      cmd(16'h0400);
      wr(6'h04, 16'h0003);
      wr(6'h08, 16'h3f05);
      chk(timer_value_out, 20'h50003);
      chk({14'h0, vbin_count_out}, 20'h3f);
      rd(6'h24, 16'h0003);
      rd(6'h28, 16'h3f05);
      cmd(16'h0402);
      cmd(16'h0400);
      repeat (4 * TK) @(negedge clock_in);
      chk(timer_value_out, 20'h50003);
      chk({19'h0, exposing_out}, 20'h0);
      rst_ctl(16'h0400);
      wr(6'h04, 16'h0003);
      wr(6'h08, 16'h0200);
      chk(timer_value_out, 20'h00003);
   endtask

   task automatic t_expose;
      int n;
      slow = 1'b0;
      cmd(16'h0082);
      cmd(16'h0080);
      wait_on(0, 6, n);
      chk({19'h0, shutter_open_out}, 20'h1);
      wait_on(1, 3 * TK + 4, n);
      chk({19'h0, n >= 3 * TK && n <= 3 * TK + 2}, 20'h1);
      wait_on(2, 30, n);
      cmd(16'h0290);
      cmd(16'h0080);
      wait_on(3, 6, n);
      slow = 1'b1;
      cmd(16'h0880);
      cmd(16'h0080);
      wait_on(6, 6, n);
      wait_on(2, 30, n);
   endtask

   task automatic t_dark_flush;
      int n;
      rst_ctl(16'h0000);
      cmd(16'h1000);
      cmd(16'h0000);
      wait_on(4, 6, n);
      cmd(16'h0040);
      cmd(16'h0000);
      repeat (4) @(negedge clock_in);
      chk({19'h0, flush_active_out}, 20'h0);
      cmd(16'h0400);
      wr(6'h04, 16'h0010);
      cmd(16'h0002);
      cmd(16'h0000);
      wait_on(0, 6, n);
      chk({19'h0, shutter_open_out}, 20'h0);
      rst_ctl(16'h0000);
      @(negedge clock_in);
      chk({19'h0, exposing_out}, 20'h0);
      cmd(16'h0200);
      cmd(16'h0000);
      repeat (2) @(negedge clock_in);
      chk({19'h0, line_ack_out}, 20'h0);
   endtask

   task automatic t_trigger;
      int n;
      cmd(16'h0400);
      wr(6'h04, 16'h0004);
      cmd(16'h0000);
      ext_trigger_in = 1'b1;
      repeat (10) @(negedge clock_in);
      chk({19'h0, exposing_out}, 20'h0);
      ext_trigger_in = 1'b0;
      cmd(16'h0020);
      ext_trigger_in = 1'b1;
      wait_on(0, 8, n);
      ext_trigger_in = 1'b0;
      repeat (2 * TK) @(negedge clock_in);
      rd(6'h24, 16'h0002);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      failures = 0;
      checks_done = 0;
      rst_b_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 6'h00;
      reg_wdata_in = 16'h0000;
      ext_trigger_in = 1'b0;
      slow = 1'b0;
      repeat (3) @(negedge clock_in);
      rst_b_in = 1'b1;
      t_reset_regs;
      t_levels;
      t_timer;
      t_expose;
      t_dark_flush;
      t_trigger;
      print_verdict;
   end
endmodule
`default_nettype wire

/* verilog/ccdet_fall_detect.v */
// one-cycle pulses on every 1-to-0 transition of a register's bits
`timescale 1ns/1ps
`default_nettype none

module ccdet_fall_detect #(
   parameter WIDTH = 16
) (
   // clock and reset
   input  wire             clock_in,
   input  wire             rst_b_in,
   // level in, pulses out
   input  wire [WIDTH-1:0] level_in,
   output wire [WIDTH-1:0] fall_out
);

   reg [WIDTH-1:0] prev_q;
   reg [WIDTH-1:0] fall_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               prev_q[i] <= 1'b0;
               fall_q[i] <= 1'b0;
            end else begin
               prev_q[i] <= level_in[i];
               fall_q[i] <= prev_q[i] & ~level_in[i];
            end
         end
      end
   endgenerate

   assign fall_out = fall_q;

endmodule

`default_nettype wire

/* verilog/ccdet_tick_gen.v */
// divider that makes the hundredth-second enable pulse for the exposure timer
`timescale 1ns/1ps
`default_nettype none

module ccdet_tick_gen #(
   parameter CYCLES = 2000000,
   parameter CW     = 24
) (
   // clock and reset
   input  wire clock_in,
   input  wire rst_b_in,
   // control
   input  wire restart_in,
   output reg  tick_out
);

   // the terminal count is cut to the counter width on purpose
   localparam integer  LAST_I = CYCLES - 1;
   localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

   reg [CW-1:0] count_q;

   // restart aligns the first step to a full period after exposure start
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count_q  <= {CW{1'b0}};
         tick_out <= 1'b0;
      end else if (restart_in) begin
         count_q  <= {CW{1'b0}};
         tick_out <= 1'b0;
      end else if (count_q == LAST) begin
         count_q  <= {CW{1'b0}};
         tick_out <= 1'b1;
      end else begin
         count_q  <= count_q + {{(CW-1){1'b0}}, 1'b1};
         tick_out <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* verilog/ccdet_top.v */
// command register, exposure timer and binning register with the exposure/line sequencer
// ==========================================================
// Notes on behaviour
// - command bit 0 enables drift scan only when the firmware supports it.
// - bit 1 falling starts exposure, then row skip, then first line digitize.
// - bit 2 set forces shutter open; clearing it only drops the force.
// - bit 3 falling resets the control logic.
// - bit 5 set lets an external trigger start exposure; host clears otherwise.
// - bit 6 falling stops continuous flushing.
// - bit 7 decides whether shutter opens while the timer runs.
// - bit 8 set ramps the cooler toward ambient at a controlled rate.
// - bit 9 falling acknowledges that the host read the current line.
// - timer loads only with bit 10 set and does not run while set.
// - bit 11 falling acquires the next line.
// - bit 12 falling starts continuous flushing of the sensor.
// - bit 13 set selects the faster lower quality subframe readout.
// - bit 14 selects cable timing, 0 short, 1 long.
// - bit 15 set regulates temperature; clear lets the head drift to ambient.
// - exposure timer is 20 bits in hundredth-second steps.
// - timer low 16 bits from timer register, upper 4 from binning bits 3:0.
// - reading the timer register returns the present running value.
// - binning register bits 13:8 hold vertical binning 0 to 63.
`timescale 1ns/1ps
`default_nettype none
`include "ccdet_map.vh"

module ccdet_top #(
   parameter TICK_CYCLES          = `CCDET_TICK_CYCLES,
   parameter DRIFT_SCAN_SUPPORTED = 1
) (
   // clock and reset
   input  wire        clock_in,
   input  wire        rst_b_in,
   // host register port
   input  wire [5:0]  reg_addr_in,
   input  wire        reg_wr_in,
   input  wire [15:0] reg_wdata_in,
   input  wire        reg_rd_in,
   output reg  [15:0] reg_rdata_out,
   output reg         reg_rvalid_out,
   // external trigger pin
   input  wire        ext_trigger_in,
   // readout engine handshake
   output wire        row_skip_req_out,
   input  wire        row_skip_done_in,
   output wire        line_req_out,
   input  wire        line_done_in,
   output wire        line_ready_out,
   output wire        line_ack_out,
   output wire        flush_active_out,
   output wire        exposing_out,
   output wire        ctrl_reset_out,
   // level controls to the head
   output wire        shutter_open_out,
   output wire        drift_scan_out,
   output wire        line_cache_out,
   output wire        cooler_ramp_out,
   output wire        cooler_regulate_out,
   output wire        focus_mode_out,
   output wire        long_cable_out,
   output wire [5:0]  vbin_count_out,
   output wire [19:0] timer_value_out
);

   // ==========================================================
   // sequencer states
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_FLUSH  = 3'h1;
   localparam [2:0] ST_EXPOSE = 3'h2;
   localparam [2:0] ST_SKIP   = 3'h3;
   localparam [2:0] ST_LINE   = 3'h4;
   localparam [2:0] ST_READY  = 3'h5;
   localparam [2:0] ST_ACKED  = 3'h6;

   localparam [19:0] TIMER_ONE = 20'h00001;

   // ==========================================================
   // registers and wires
   reg  [15:0] cmd_q;
   reg  [19:0] timer_q;
   reg  [19:0] timer_d;
   reg  [5:0]  vbin_q;
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg         skip_req_q;
   reg         skip_req_d;
   reg         line_req_q;
   reg         line_req_d;
   reg         line_ack_q;
   reg         ctrl_reset_q;
   reg         trig_meta_q;
   reg         trig_sync_q;
   reg         trig_prev_q;
   reg         tick_restart;
   wire [15:0] cmd_fall;
   wire        tick;
   wire        trig_rise;
   wire        wr_cmd;
   wire        wr_tlow;
   wire        wr_vbin;
   wire        timer_load_en;
   wire        start_expo;
   wire        start_line;
   wire        start_flush;
   wire        stop_flush;
   wire        done_read;
   wire        reset_ctrl;

   // ==========================================================
   // register writes
   assign wr_cmd  = reg_wr_in && (reg_addr_in == `CCDET_WR_COMMAND);
   assign wr_tlow = reg_wr_in && (reg_addr_in == `CCDET_WR_TIMER_LOW);
   assign wr_vbin = reg_wr_in && (reg_addr_in == `CCDET_WR_VBIN);

   assign timer_load_en = cmd_q[`CCDET_CMD_TIMER_LOAD];

   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd_q <= `CCDET_COMMAND_RESET;
      end else if (wr_cmd) begin
         cmd_q <= reg_wdata_in;
      end
   end

   // binning count is stored on every write; bits 7:4 and 15:14 are not kept
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         vbin_q <= `CCDET_VBIN_RESET;
      end else if (wr_vbin) begin
         vbin_q <= reg_wdata_in[`CCDET_VBIN_COUNT_MSB:`CCDET_VBIN_COUNT_LSB];
      end
   end

   // ==========================================================
   // falling-edge detection of every command bit
   ccdet_fall_detect #(
      .WIDTH (16)
   ) u_fall (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .level_in (cmd_q),
      .fall_out (cmd_fall)
   );

   assign start_expo  = cmd_fall[`CCDET_CMD_START_EXPO];
   assign reset_ctrl  = cmd_fall[`CCDET_CMD_CTRL_RESET];
   assign stop_flush  = cmd_fall[`CCDET_CMD_STOP_FLUSH];
   assign done_read   = cmd_fall[`CCDET_CMD_DONE_READ];
   assign start_line  = cmd_fall[`CCDET_CMD_NEXT_LINE];
   assign start_flush = cmd_fall[`CCDET_CMD_START_FLUSH];

   // ==========================================================
   // external trigger: two-flop synchroniser, edge taken after it
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_meta_q <= 1'b0;
         trig_sync_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_meta_q <= ext_trigger_in;
         trig_sync_q <= trig_meta_q;
         trig_prev_q <= trig_sync_q;
      end
   end

   // a held trigger line starts only one exposure
   assign trig_rise = trig_sync_q & ~trig_prev_q & cmd_q[`CCDET_CMD_TRIG_ENABLE];

   // ==========================================================
   // hundredth-second step
   ccdet_tick_gen #(
      .CYCLES (TICK_CYCLES),
      .CW     (24)
   ) u_tick (
      .clock_in   (clock_in),
      .rst_b_in   (rst_b_in),
      .restart_in (tick_restart),
      .tick_out   (tick)
   );

   // ==========================================================
   // sequencer next state
   always @* begin
      state_d      = state_q;
      skip_req_d   = 1'b0;
      line_req_d   = 1'b0;
      tick_restart = 1'b0;
      case (state_q)
         ST_IDLE, ST_FLUSH, ST_READY, ST_ACKED: begin
            if (start_expo || (trig_rise && (state_q == ST_IDLE || state_q == ST_FLUSH))) begin
               state_d      = ST_EXPOSE;
               tick_restart = 1'b1;
            end else if (start_line && state_q != ST_FLUSH) begin
               state_d    = ST_LINE;
               line_req_d = 1'b1;
            end else if (start_flush && state_q != ST_FLUSH) begin
               state_d = ST_FLUSH;
            end else if (stop_flush && state_q == ST_FLUSH) begin
               state_d = ST_IDLE;
            end else if (done_read && state_q == ST_READY) begin
               state_d = ST_ACKED;
            end
         end
         ST_EXPOSE: begin
            // the step divider is held while loading so a step never lands mid-load
            if (timer_load_en) begin
               tick_restart = 1'b1;
            end else if (timer_q == `CCDET_TIMER_RESET) begin
               state_d    = ST_SKIP;
               skip_req_d = 1'b1;
            end
         end
         ST_SKIP: begin
            if (row_skip_done_in) begin
               state_d    = ST_LINE;
               line_req_d = 1'b1;
            end
         end
         ST_LINE: begin
            if (line_done_in) begin
               state_d = ST_READY;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // sequencer state and handshake flops
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q      <= ST_IDLE;
         skip_req_q   <= 1'b0;
         line_req_q   <= 1'b0;
         line_ack_q   <= 1'b0;
         ctrl_reset_q <= 1'b0;
      end else if (reset_ctrl) begin
         state_q      <= ST_IDLE;
         skip_req_q   <= 1'b0;
         line_req_q   <= 1'b0;
         line_ack_q   <= 1'b0;
         ctrl_reset_q <= 1'b1;
      end else begin
         state_q      <= state_d;
         skip_req_q   <= skip_req_d;
         line_req_q   <= line_req_d;
         line_ack_q   <= done_read && (state_q == ST_READY);
         ctrl_reset_q <= 1'b0;
      end
   end

   // ==========================================================
   // exposure timer: load, hold and count down
   always @* begin
      timer_d = timer_q;
      if (timer_load_en) begin
         if (wr_tlow) begin
            timer_d[15:0] = reg_wdata_in;
         end
         if (wr_vbin) begin
            timer_d[19:16] = reg_wdata_in[`CCDET_VBIN_TMR_HI_MSB:`CCDET_VBIN_TMR_HI_LSB];
         end
      end else if (state_q == ST_EXPOSE && tick && timer_q != `CCDET_TIMER_RESET) begin
         timer_d = timer_q - TIMER_ONE;
      end
   end

   // a control reset stops the count but keeps the value the timer has reached
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         timer_q <= `CCDET_TIMER_RESET;
      end else begin
         timer_q <= timer_d;
      end
   end

   // ==========================================================
   // register reads, one cycle after the strobe
   always @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `CCDET_RD_COMMAND: begin
                  reg_rdata_out <= cmd_q;
               end
               `CCDET_RD_TIMER_LOW: begin
                  reg_rdata_out <= timer_q[15:0];
               end
               `CCDET_RD_VBIN: begin
                  reg_rdata_out <= {2'h0, vbin_q, 4'h0, timer_q[19:16]};
               end
               default: begin
                  reg_rdata_out <= 16'h0000;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // outputs
   assign row_skip_req_out = skip_req_q;
   assign line_req_out     = line_req_q;
   assign line_ready_out   = (state_q == ST_READY);
   assign line_ack_out     = line_ack_q;
   assign flush_active_out = (state_q == ST_FLUSH);
   assign exposing_out     = (state_q == ST_EXPOSE) && !timer_load_en;
   assign ctrl_reset_out   = ctrl_reset_q;

   // override wins; otherwise the shutter follows the enable only while timing
   assign shutter_open_out = cmd_q[`CCDET_CMD_SHUT_FORCE] |
                             (exposing_out & cmd_q[`CCDET_CMD_SHUT_ENABLE]);

   // without drift-scan support the bit is stored but never reaches the head
   assign drift_scan_out      = (DRIFT_SCAN_SUPPORTED != 0) & cmd_q[`CCDET_CMD_DRIFT_SCAN];
   assign line_cache_out      = cmd_q[`CCDET_CMD_LINE_CACHE];
   assign cooler_ramp_out     = cmd_q[`CCDET_CMD_COOL_RAMP];
   assign cooler_regulate_out = cmd_q[`CCDET_CMD_COOL_ENABLE];
   assign focus_mode_out      = cmd_q[`CCDET_CMD_FOCUS];
   assign long_cable_out      = cmd_q[`CCDET_CMD_LONG_CABLE];
   assign vbin_count_out      = vbin_q;
   assign timer_value_out     = timer_q;

endmodule

`default_nettype wire
